// ### mgmt_host_model.sv
// station management controller model: sends serial frames, samples read data
// assumes the bench resolves the shared wire with a pull-up and returns it on mdio_i
`timescale 1ns/1ps
module mgmt_host_model (
  input  wire logic clk_i,
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_oe_o
);
  // idle: clock low, wire released to the pull-up
  initial begin
    mdc_o     = 1'b0;
    mdio_o    = 1'b1;
    mdio_oe_o = 1'b0;
  end

  // full frame with 32 preamble ones; mdc high spans 4 clk and low spans 5 clk, above the minimum of 2
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wdata, output logic [15:0] rdata);
    logic [63:0] v;
    v = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wdata};
    rdata = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      @(negedge clk_i);
      mdio_o    <= v[63-i];
      mdio_oe_o <= !(op == phy_regs_pkg::OP_READ && i >= 46); // let go for turnaround
      repeat (4) @(negedge clk_i);
      mdc_o <= 1'b1;
      // sampled at the rise, before the device moves on to its next bit
      if (op == phy_regs_pkg::OP_READ && i >= 48) rdata = {rdata[14:0], mdio_i};
      repeat (4) @(negedge clk_i);
      mdc_o <= 1'b0;
    end
    @(negedge clk_i);
    mdio_oe_o <= 1'b0;
  endtask
endmodule

// ### phy_regs_pkg.sv
// constants and types for the management register slice of the transceiver
// assumes a single management clock domain and frame-level serial access
package phy_regs_pkg;

  // register offsets on the serial management interface
  localparam logic [4:0] STATUS_OFFSET    = 5'h01;
  localparam logic [4:0] ID_HIGH_OFFSET   = 5'h02;
  localparam logic [4:0] ID_LOW_OFFSET    = 5'h03;

  // status register field positions and reset values
  localparam int         JABBER_BIT       = 1;
  localparam int         EXT_CAP_BIT      = 0;
  localparam logic       JABBER_RESET     = 1'h0;

  // frame layout, counted in serial clock rising edges
  localparam logic [5:0] PREAMBLE_LEN     = 6'h20;
  localparam logic [4:0] HDR_BITS         = 5'h0D;
  localparam logic [4:0] DATA_BITS        = 5'h10;
  localparam logic [1:0] OP_READ          = 2'h2;
  localparam logic [1:0] OP_WRITE         = 2'h1;

  // identity values: arbitrary, not any real maker's codes
  localparam logic [21:0] VENDOR_CODE     = 22'h15A5A5;
  localparam logic [5:0]  MODEL_NUMBER    = 6'h0C;
  localparam logic [3:0]  MODEL_REVISION  = 4'h3;

  // frame header after the first start bit
  typedef struct packed {
    logic       start_lo;
    logic [1:0] opcode;
    logic [4:0] phy_addr;
    logic [4:0] reg_addr;
  } frame_hdr_t;

  typedef enum logic [1:0] {
    ST_PREAMBLE   = 2'b00,
    ST_HEADER     = 2'b01,
    ST_TURNAROUND = 2'b10,
    ST_DATA       = 2'b11
  } mgmt_state_t;

endpackage

// ### phy_status_and_identity_regs.sv
// status tail and identity registers behind the serial management pins
// assumes mdc_i and mdio_i are synchronous to clk_i and mdc is well slower
`timescale 1ns/1ps

module phy_status_and_identity_regs #(
  parameter bit ZERO_IDENTITY = 1'b0
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [4:0] phy_addr_i,
  input  wire logic       jabber_event_i,
  input  wire logic       mdc_i,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe_o,
  output logic            jabber_flag_o
);

  phy_regs_pkg::mgmt_state_t state_q;
  phy_regs_pkg::frame_hdr_t  hdr_q;
  phy_regs_pkg::frame_hdr_t  hdr_d;
  logic        mdc_q;
  logic        mdc_rise;
  logic [5:0]  pre_cnt_q;
  logic [4:0]  cnt_q;
  logic        rd_q;
  logic [15:0] shift_q;
  logic        jabber_q;
  logic        mdio_q;
  logic        mdio_oe_q;
  logic        hdr_done;
  logic        rd_hit;
  logic        wr_ok;
  logic        status_read;

  // register read mux, loaded into the read shift register at header end
  function automatic logic [15:0] reg_read(input logic [4:0] addr, input logic jab);
    logic [15:0] v;
    v = 16'h0000;
    unique case (addr)
      phy_regs_pkg::STATUS_OFFSET: begin
        v[phy_regs_pkg::JABBER_BIT]  = jab;
        v[phy_regs_pkg::EXT_CAP_BIT] = 1'b1;
      end
      phy_regs_pkg::ID_HIGH_OFFSET: begin
        v = phy_regs_pkg::VENDOR_CODE[21:6];
      end
      phy_regs_pkg::ID_LOW_OFFSET: begin
        v = {phy_regs_pkg::VENDOR_CODE[5:0], phy_regs_pkg::MODEL_NUMBER,
             phy_regs_pkg::MODEL_REVISION};
      end
      default: v = 16'h0000;
    endcase
    if (ZERO_IDENTITY && (addr == phy_regs_pkg::ID_HIGH_OFFSET ||
                          addr == phy_regs_pkg::ID_LOW_OFFSET)) begin
      v = 16'h0000;
    end
    return v;
  endfunction

  // header decode on the last header bit
  assign mdc_rise    = mdc_i & ~mdc_q;
  assign hdr_d       = {hdr_q[11:0], mdio_i};
  assign hdr_done    = mdc_rise && (state_q == phy_regs_pkg::ST_HEADER) &&
                       (cnt_q == phy_regs_pkg::HDR_BITS - 5'h01);
  assign rd_hit      = hdr_d.start_lo && (hdr_d.opcode == phy_regs_pkg::OP_READ) &&
                       (hdr_d.phy_addr == phy_addr_i);
  assign wr_ok       = hdr_d.start_lo && (hdr_d.opcode == phy_regs_pkg::OP_WRITE);
  assign status_read = hdr_done && rd_hit && (hdr_d.reg_addr == phy_regs_pkg::STATUS_OFFSET);

  // serial clock edge detect; inputs are already synchronous
  // reset value matches the idle-low serial clock, so no false edge follows reset
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mdc_q <= 1'b0;
    end else begin
      mdc_q <= mdc_i;
    end
  end

  // jabber latch: a new event wins over a same-cycle read clear
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      jabber_q <= phy_regs_pkg::JABBER_RESET;
    end else if (jabber_event_i) begin
      jabber_q <= 1'b1;
    end else if (status_read) begin
      jabber_q <= 1'b0;
    end
  end

  // frame sequencer, advancing once per serial clock rising edge
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q   <= phy_regs_pkg::ST_PREAMBLE;
      pre_cnt_q <= 6'h00;
      cnt_q     <= 5'h00;
      hdr_q     <= '0;
      rd_q      <= 1'b0;
    end else if (mdc_rise) begin
      unique case (state_q)
        phy_regs_pkg::ST_PREAMBLE: begin
          if (mdio_i) begin
            // saturate so a long idle-high run still qualifies as preamble
            if (pre_cnt_q != phy_regs_pkg::PREAMBLE_LEN) begin
              pre_cnt_q <= pre_cnt_q + 6'h01;
            end
          end else begin
            // first start bit only counts after a full preamble
            pre_cnt_q <= 6'h00;
            if (pre_cnt_q == phy_regs_pkg::PREAMBLE_LEN) begin
              state_q <= phy_regs_pkg::ST_HEADER;
              cnt_q   <= 5'h00;
            end
          end
        end
        phy_regs_pkg::ST_HEADER: begin
          hdr_q <= hdr_d;
          cnt_q <= cnt_q + 5'h01;
          if (hdr_done) begin
            cnt_q <= 5'h00;
            rd_q  <= rd_hit;
            // foreign reads are tracked silently; bad opcodes abort
            state_q <= (wr_ok || (hdr_d.start_lo && hdr_d.opcode == phy_regs_pkg::OP_READ)) ?
                       phy_regs_pkg::ST_TURNAROUND : phy_regs_pkg::ST_PREAMBLE;
          end
        end
        phy_regs_pkg::ST_TURNAROUND: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == 5'h01) begin
            state_q <= phy_regs_pkg::ST_DATA;
            cnt_q   <= rd_q ? 5'h01 : 5'h00;
          end
        end
        phy_regs_pkg::ST_DATA: begin
          // write data is counted but never stored: every bit here is read-only
          cnt_q <= cnt_q + 5'h01;
          if ((rd_q && cnt_q == phy_regs_pkg::DATA_BITS) ||
              (!rd_q && cnt_q == phy_regs_pkg::DATA_BITS - 5'h01)) begin
            state_q <= phy_regs_pkg::ST_PREAMBLE;
            cnt_q   <= 5'h00;
            rd_q    <= 1'b0;
          end
        end
      endcase
    end
  end

  // read data path: snapshot at header end so the word cannot tear mid-shift
  // the pin is released one rise after bit 0, which the host samples on that rise
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_q   <= 16'h0000;
      mdio_q    <= 1'b0;
      mdio_oe_q <= 1'b0;
    end else if (hdr_done) begin
      shift_q <= reg_read(hdr_d.reg_addr, jabber_q);
    end else if (mdc_rise && rd_q) begin
      if (state_q == phy_regs_pkg::ST_TURNAROUND && cnt_q == 5'h00) begin
        mdio_oe_q <= 1'b1; // second turnaround bit driven low
        mdio_q    <= 1'b0;
      end else if (state_q == phy_regs_pkg::ST_DATA && cnt_q == phy_regs_pkg::DATA_BITS) begin
        mdio_oe_q <= 1'b0;
        mdio_q    <= 1'b0;
      end else begin
        mdio_q  <= shift_q[15];
        shift_q <= {shift_q[14:0], 1'b0};
      end
    end
  end

  assign mdio_o        = mdio_q;
  assign mdio_oe_o     = mdio_oe_q;
  assign jabber_flag_o = jabber_q;

  // checks
  // identity words are held against the package constants, not the read mux
  jabber_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    jabber_event_i |=> jabber_q) else $error("jabber flag did not latch");
  jabber_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    jabber_q && !status_read |=> jabber_q) else $error("jabber flag lost without read");
  ext_cap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    status_read |=> shift_q[0] && shift_q[1] == $past(jabber_q))
    else $error("status word wrong");
  id_high_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hdr_done && hdr_d.reg_addr == phy_regs_pkg::ID_HIGH_OFFSET |=>
    shift_q == (ZERO_IDENTITY ? 16'h0000 : phy_regs_pkg::VENDOR_CODE[21:6]))
    else $error("identity high word wrong");
  id_low_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hdr_done && hdr_d.reg_addr == phy_regs_pkg::ID_LOW_OFFSET |=>
    shift_q == (ZERO_IDENTITY ? 16'h0000 : {phy_regs_pkg::VENDOR_CODE[5:0],
                phy_regs_pkg::MODEL_NUMBER, phy_regs_pkg::MODEL_REVISION}))
    else $error("identity low word wrong");
  id_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ZERO_IDENTITY && hdr_done && hdr_d.reg_addr[4:1] == 4'h1 |=> shift_q == 16'h0000)
    else $error("identity not zero");
  write_quiet_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == phy_regs_pkg::ST_DATA && !rd_q |-> !mdio_oe_q)
    else $error("pin driven during write");
  ta_low_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(mdio_oe_q) |-> !mdio_q && state_q == phy_regs_pkg::ST_TURNAROUND)
    else $error("turnaround not driven low");
  bus_release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q != phy_regs_pkg::ST_DATA && state_q != phy_regs_pkg::ST_TURNAROUND
    |-> !mdio_oe_q) else $error("pin driven outside a read");

  read_cov: cover property (@(posedge clk_i) disable iff (sys_rst_i) $fell(mdio_oe_q));
  status_cov: cover property (@(posedge clk_i) disable iff (sys_rst_i) status_read && jabber_q);
  race_cov: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    status_read && jabber_event_i);
  write_cov: cover property (@(posedge clk_i) disable iff (sys_rst_i) hdr_done && wr_ok);
  abort_cov: cover property (@(posedge clk_i) disable iff (sys_rst_i) hdr_done && !hdr_d.start_lo);

endmodule

// ### phy_status_and_identity_regs_tb.sv
// self-checking bench: two devices share one management wire with one host model
// assumes the design package and host model are compiled first
`timescale 1ns/1ps
module phy_status_and_identity_regs_tb;
  logic        clk, rst, jab, mdc, h_o, h_oe, d_o, d_oe, z_o, z_oe, flag, zflag;
  logic        mdio_w;
  logic [15:0] rd;
  logic [15:0] id_hi;
  logic [15:0] id_lo;
  int          fail_count = 0;
  int          compares = 0;
  localparam logic [4:0] PA = 5'h01;
  localparam logic [4:0] PZ = 5'h02;

  // open-drain style wire with pull-up: whoever enables drives it
  assign mdio_w = d_oe ? d_o : z_oe ? z_o : h_oe ? h_o : 1'b1;
  assign id_hi = phy_regs_pkg::VENDOR_CODE[21:6];
  assign id_lo = {phy_regs_pkg::VENDOR_CODE[5:0], phy_regs_pkg::MODEL_NUMBER,
                  phy_regs_pkg::MODEL_REVISION};

  phy_status_and_identity_regs dut (.clk_i(clk), .sys_rst_i(rst), .phy_addr_i(PA),
    .jabber_event_i(jab), .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(d_o), .mdio_oe_o(d_oe),
    .jabber_flag_o(flag));
  // second device answers at another address with the all-zero identity option
  phy_status_and_identity_regs #(.ZERO_IDENTITY(1'b1)) dut_zero (.clk_i(clk),
    .sys_rst_i(rst), .phy_addr_i(PZ), .jabber_event_i(jab), .mdc_i(mdc), .mdio_i(mdio_w),
    .mdio_o(z_o), .mdio_oe_o(z_oe), .jabber_flag_o(zflag));
  mgmt_host_model host (.clk_i(clk), .mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(h_o),
    .mdio_oe_o(h_oe));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_reg(input logic [4:0] pa, input logic [4:0] ra);
    host.frame(phy_regs_pkg::OP_READ, pa, ra, 16'h0000, rd);
  endtask

  task automatic wr_reg(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] unused;
    host.frame(phy_regs_pkg::OP_WRITE, PA, ra, d, unused);
  endtask

  task automatic end_sim;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // about 13 frames of some 580 clk each, so 200 us leaves ample margin
  initial begin
    #200_000;
    fail_count++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    jab = 1'b0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    rd_reg(PA, phy_regs_pkg::ID_HIGH_OFFSET);
    chk("id_high", id_hi, rd);
    rd_reg(PA, phy_regs_pkg::ID_LOW_OFFSET);
    chk("id_low", id_lo, rd);
    rd_reg(PA, phy_regs_pkg::STATUS_OFFSET);
    chk("status", 16'h0001, rd);
    // single-cycle jabber pulse must latch until the status read
    jab = 1'b1;
    @(negedge clk);
    jab = 1'b0;
    @(negedge clk);
    chk("flag", 16'h0001, {15'h0000, flag});
    rd_reg(PA, phy_regs_pkg::ID_HIGH_OFFSET);
    chk("flag", 16'h0001, {15'h0000, flag});
    rd_reg(PA, phy_regs_pkg::STATUS_OFFSET);
    chk("status", 16'h0003, rd);
    chk("flag", 16'h0000, {15'h0000, flag});
    rd_reg(PA, phy_regs_pkg::STATUS_OFFSET);
    chk("status", 16'h0001, rd);
    // writes to read-only places leave them as they were
    wr_reg(phy_regs_pkg::ID_HIGH_OFFSET, 16'h0000);
    wr_reg(phy_regs_pkg::STATUS_OFFSET, 16'hFFFE);
    rd_reg(PA, phy_regs_pkg::ID_HIGH_OFFSET);
    chk("id_high", id_hi, rd);
    rd_reg(PA, phy_regs_pkg::STATUS_OFFSET);
    chk("status", 16'h0001, rd);
    rd_reg(PZ, phy_regs_pkg::ID_HIGH_OFFSET);
    chk("zero_high", 16'h0000, rd);
    rd_reg(PZ, phy_regs_pkg::ID_LOW_OFFSET);
    chk("zero_low", 16'h0000, rd);
    // second device still holds the first pulse; its status read clears it
    rd_reg(PZ, phy_regs_pkg::STATUS_OFFSET);
    chk("zero_status", 16'h0003, rd);
    chk("zflag", 16'h0000, {15'h0000, zflag});
    // reset alone also clears a latched jabber flag
    jab = 1'b1;
    @(negedge clk);
    jab = 1'b0;
    chk("flag", 16'h0001, {15'h0000, flag});
    chk("zflag", 16'h0001, {15'h0000, zflag});
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("flag", 16'h0000, {15'h0000, flag});
    chk("zflag", 16'h0000, {15'h0000, zflag});
    end_sim();
  end
endmodule
